/* File: hw/defect_map_regs.vh */
/*
 framer constants: offsets, control bits,
 layout, crc.
 assumes inclusion by the framer only.
*/
`ifndef DEFECT_MAP_REGS_VH
`define DEFECT_MAP_REGS_VH

// ==============================================
// registers and control bits
`define A_CTRL        8'h00
`define A_STATUS      8'h04
`define A_MAP_CYL     8'h08
`define A_MAP_GEOM    8'h0C
`define A_FS_CYL      8'h10
`define A_FS_HEAD     8'h14
`define A_TRK_LEN     8'h18
`define A_ENT_CYL     8'h1C
`define A_ENT_HEAD    8'h20
`define A_ENT_DIST    8'h24
`define A_ENT_LEN     8'h28
`define CTRL_START    0
`define CTRL_CLEAR    1

// ==============================================
// sector layout
`define HDR_END       16'h000E
`define CNT_FIELD     16'h00FE
`define CRC_HI        16'h00FE
`define CRC_LO        16'h00FF
`define ENT_LAST_OCT  4'hB
`define ENT_PER_FIELD 8'h14
`define ENT_DEPTH     64
`define ENT_FULL      7'h40
`define COPIES_LAST   2'h2
`define FNUM_IGNORE   8'hFF
`define ENC_TRACK     2'h0

// ==============================================
// crc-16, x^16 + x^15 + x^2 + 1, all-ones seed
`define CRC_POLY      16'h8005
`define CRC_SEED      16'hFFFF

// ==============================================
// axi responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

/* File: hw/defect_map_framer.v */
/*
 defect map sector framer: defect list from axi4-lite,
 recorded as sets of three map data fields,
 one octet at a time.
 assumes a formatter taking octets on rec_valid/rec_ready
 and flagging unreadable sectors on sector_bad.
// Functional notes
// RULE_01: map starts last track, runs backward
// RULE_02: each set records sector three times
// RULE_03: unreadable sector marked, extra sector added
// RULE_04: entries twelve octets, offsets from index
// RULE_05: offset folds ordered head times length
// RULE_06: out-of-order entries flag their field
// RULE_07: header field holds no map content
// RULE_08: leading count excludes itself
// RULE_09: flag octet last, continue, encoding, sequence
// RULE_10: field number 0/1/2, FF ignore
// RULE_11: set total and set number octets
// RULE_12: sets from one; empty map zero
// RULE_13: last format storage cylinder and head
// RULE_14: descriptor cylinder, head, offset, length
// RULE_15: entries never split; zero padding
// RULE_16: last two octets hold crc
// RULE_17: copies differ only in field number
// RULE_18: map tracks use maker format
// RULE_19: crc polynomial 8005, seed all ones
// RULE_20: crc taken msb first
// RULE_21: encoding 00 is track defect list
// RULE_22: reader drops bad or ignored fields
// RULE_23: crc covers count through padding
*/
`timescale 1ns/100ps
`default_nettype none
`include "defect_map_regs.vh"

module defect_map_framer (
   input  wire        sys_clk,        // 200 mhz clock
   input  wire        rst_b,          // sync reset, active low
   input  wire [7:0]  s_axi_awaddr,   // write address
   input  wire        s_axi_awvalid,  // write address valid
   output wire        s_axi_awready,  // write address ready
   input  wire [31:0] s_axi_wdata,    // write data
   input  wire [3:0]  s_axi_wstrb,    // write strobes
   input  wire        s_axi_wvalid,   // write data valid
   output wire        s_axi_wready,   // write data ready
   output reg  [1:0]  s_axi_bresp,    // write response
   output reg         s_axi_bvalid,   // write response valid
   input  wire        s_axi_bready,   // write response ready
   input  wire [7:0]  s_axi_araddr,   // read address
   input  wire        s_axi_arvalid,  // read address valid
   output wire        s_axi_arready,  // read address ready
   output reg  [31:0] s_axi_rdata,    // read data
   output reg  [1:0]  s_axi_rresp,    // read response
   output reg         s_axi_rvalid,   // read data valid
   input  wire        s_axi_rready,   // read data ready
   output reg  [7:0]  rec_data,       // octet to record
   output reg         rec_valid,      // octet valid
   input  wire        rec_ready,      // formatter takes octet
   output reg         rec_first,      // first octet of field
   output reg         rec_last,       // last octet of field
   output reg  [31:0] rec_cyl,        // cylinder being recorded
   output reg  [15:0] rec_head,       // head being recorded
   output reg  [15:0] rec_sector,     // sector on track
   input  wire        sector_bad,     // target sector unreadable
   output reg         mfr_format      // use maker format spec
);

   localparam S_IDLE = 2'd0;
   localparam S_RUN  = 2'd1;
   localparam S_DONE = 2'd2;

   // ==============================================
   // helpers
   function addr_ok;
      input [7:0] a;
      begin
         addr_ok = (a[1:0] == 2'h0) && (a <= `A_ENT_LEN);
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b])
               merge[8*b +: 8] = nw[8*b +: 8];
         end
      end
   endfunction

   function [15:0] crc_byte;
      input [15:0] c;
      input [7:0]  d;
      integer      i;
      reg   [15:0] r;
      begin
         r = c;
         for (i = 7; i >= 0; i = i - 1) begin
            if (r[15] ^ d[i]) // [RULE_20]
               r = {r[14:0], 1'b0} ^ `CRC_POLY; // [RULE_19]
            else
               r = {r[14:0], 1'b0};
         end
         crc_byte = r;
      end
   endfunction

   // ==============================================
   // state
   reg         aw_hold_reg;
   reg  [7:0]  aw_addr_reg;
   reg         w_hold_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   reg  [31:0] map_cyl_reg;
   reg  [15:0] map_head_reg;
   reg  [15:0] spt_reg;
   reg  [31:0] fs_cyl_reg;
   reg  [15:0] fs_head_reg;
   reg  [31:0] trk_len_reg;
   reg  [31:0] e_cyl_reg;
   reg  [15:0] e_head_reg;
   reg  [15:0] e_ohead_reg;
   reg  [31:0] e_dist_reg;
   reg  [95:0] ent_mem [0:`ENT_DEPTH-1];
   reg  [79:0] prev_key_reg;
   reg  [6:0]  n_ent_reg;
   reg  [7:0]  push_slot_reg;
   reg  [7:0]  push_field_reg;
   reg  [3:0]  fld_oos_reg;
   reg  [1:0]  state_reg;
   reg  [15:0] idx_reg;
   reg  [3:0]  k_reg;
   reg  [7:0]  eif_reg;
   reg  [7:0]  set_base_reg;
   reg  [7:0]  set_no_reg;
   reg  [1:0]  copy_reg;
   reg         bad_reg;
   reg         cont_reg;
   reg  [15:0] crc_reg;
   reg  [31:0] cyl_reg;
   reg  [15:0] head_reg;
   reg  [15:0] sector_reg;

   wire        do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
   wire        busy     = (state_reg == S_RUN);
   wire        full     = (n_ent_reg == `ENT_FULL);
   wire [31:0] wr_val   = merge(32'h0, w_data_reg, w_strb_reg);
   wire        wr_ctrl  = do_write && (aw_addr_reg == `A_CTRL);
   wire        start    = wr_ctrl && wr_val[`CTRL_START] && !busy;
   wire        clear    = wr_ctrl && wr_val[`CTRL_CLEAR] && !busy;
   wire        push     = do_write && (aw_addr_reg == `A_ENT_LEN) && !busy && !full;
   wire [7:0]  sets_tot = push_field_reg + {7'h0, (push_slot_reg != 8'h0)};
   wire [7:0]  sets_run = (sets_tot == 8'h0) ? 8'h1 : sets_tot;

   // folded offset of pushed entry
   wire [31:0] fold_mul = e_ohead_reg * trk_len_reg[15:0];
   wire [31:0] fold_off = e_dist_reg + fold_mul; // [RULE_05]
   wire [79:0] new_key  = {e_cyl_reg, e_head_reg, fold_off};
   wire        new_oos  = (n_ent_reg != 7'h0) && (new_key < prev_key_reg);

   assign s_axi_awready = ~aw_hold_reg;
   assign s_axi_wready  = ~w_hold_reg;
   assign s_axi_arready = ~s_axi_rvalid;

   // ==============================================
   // axi write path and entry store
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         aw_hold_reg    <= 1'b0;
         aw_addr_reg    <= 8'h00;
         w_hold_reg     <= 1'b0;
         w_data_reg     <= 32'h0;
         w_strb_reg     <= 4'h0;
         s_axi_bvalid   <= 1'b0;
         s_axi_bresp    <= `RESP_OKAY;
         map_cyl_reg    <= 32'h0;
         map_head_reg   <= 16'h0;
         spt_reg        <= 16'h1;
         fs_cyl_reg     <= 32'h0;
         fs_head_reg    <= 16'h0;
         trk_len_reg    <= 32'h0;
         e_cyl_reg      <= 32'h0;
         e_head_reg     <= 16'h0;
         e_ohead_reg    <= 16'h0;
         e_dist_reg     <= 32'h0;
         prev_key_reg   <= 80'h0;
         n_ent_reg      <= 7'h0;
         push_slot_reg  <= 8'h0;
         push_field_reg <= 8'h0;
         fld_oos_reg    <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_hold_reg) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_reg) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_ok(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
            case (aw_addr_reg)
               `A_MAP_CYL:  map_cyl_reg <= merge(map_cyl_reg, w_data_reg, w_strb_reg);
               `A_MAP_GEOM: {spt_reg, map_head_reg} <=
                               merge({spt_reg, map_head_reg}, w_data_reg, w_strb_reg);
               `A_FS_CYL:   fs_cyl_reg <= merge(fs_cyl_reg, w_data_reg, w_strb_reg);
               `A_FS_HEAD:  fs_head_reg <= wr_val[15:0];
               `A_TRK_LEN:  trk_len_reg <= merge(trk_len_reg, w_data_reg, w_strb_reg);
               `A_ENT_CYL:  e_cyl_reg <= merge(e_cyl_reg, w_data_reg, w_strb_reg);
               `A_ENT_HEAD: {e_ohead_reg, e_head_reg} <=
                               merge({e_ohead_reg, e_head_reg}, w_data_reg, w_strb_reg);
               `A_ENT_DIST: e_dist_reg <= merge(e_dist_reg, w_data_reg, w_strb_reg);
               default: ;
            endcase
         end
         if (push) begin
            ent_mem[n_ent_reg[5:0]] <= {new_key, wr_val[15:0]};  // [RULE_04] [RULE_14]
            prev_key_reg <= new_key;
            n_ent_reg    <= n_ent_reg + 7'h1;
            if (new_oos)
               fld_oos_reg[push_field_reg[1:0]] <= 1'b1;     // [RULE_06]
            if (push_slot_reg == `ENT_PER_FIELD - 8'h1) begin
               push_slot_reg  <= 8'h0;
               push_field_reg <= push_field_reg + 8'h1;
            end else
               push_slot_reg <= push_slot_reg + 8'h1;
         end
         if (clear) begin
            n_ent_reg      <= 7'h0;
            push_slot_reg  <= 8'h0;
            push_field_reg <= 8'h0;
            fld_oos_reg    <= 4'h0;
         end
      end
   end

   // ==============================================
   // axi read path
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         case (s_axi_araddr)
            `A_STATUS:   s_axi_rdata <= {busy, state_reg == S_DONE, full, 13'h0,
                                         sets_tot, 1'b0, n_ent_reg};
            `A_MAP_CYL:  s_axi_rdata <= map_cyl_reg;
            `A_MAP_GEOM: s_axi_rdata <= {spt_reg, map_head_reg};
            `A_FS_CYL:   s_axi_rdata <= fs_cyl_reg;
            `A_FS_HEAD:  s_axi_rdata <= {16'h0, fs_head_reg};
            `A_TRK_LEN:  s_axi_rdata <= trk_len_reg;
            `A_ENT_CYL:  s_axi_rdata <= e_cyl_reg;
            `A_ENT_HEAD: s_axi_rdata <= {e_ohead_reg, e_head_reg};
            `A_ENT_DIST: s_axi_rdata <= e_dist_reg;
            default:     s_axi_rdata <= 32'h0;
         endcase
      end else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ==============================================
   // octet for current field position
   wire [7:0]  ent_idx  = set_base_reg + eif_reg;
   wire        ent_ok   = ({1'b0, n_ent_reg} > ent_idx);
   wire [95:0] ent_word = ent_mem[ent_idx[5:0]];
   wire [95:0] ent_shft = ent_word << {k_reg, 3'b000};
   wire [15:0] cnt_val  = `CNT_FIELD; // [RULE_08]
   wire [7:0]  flag_oct = {set_no_reg == sets_run, // [RULE_09]
                           cont_reg, `ENC_TRACK, // [RULE_21]
                           fld_oos_reg[set_no_reg[1:0] - 2'h1], 3'b000};
   wire [7:0]  fnum     = bad_reg ? `FNUM_IGNORE : {6'h0, copy_reg}; // [RULE_10] [RULE_03]
   wire        in_ent   = (idx_reg >= `HDR_END) && (idx_reg < `CRC_HI);
   reg  [7:0]  oct;

   always @* begin
      case (idx_reg)
         16'h0000: oct = cnt_val[15:8];
         16'h0001: oct = cnt_val[7:0];
         16'h0002: oct = flag_oct;
         16'h0003: oct = fnum; // [RULE_17]
         16'h0004: oct = 8'h00;
         16'h0005: oct = sets_tot; // [RULE_11] [RULE_12]
         16'h0006: oct = 8'h00;
         16'h0007: oct = set_no_reg;
         16'h0008: oct = fs_cyl_reg[31:24]; // [RULE_13]
         16'h0009: oct = fs_cyl_reg[23:16];
         16'h000A: oct = fs_cyl_reg[15:8];
         16'h000B: oct = fs_cyl_reg[7:0];
         16'h000C: oct = fs_head_reg[15:8];
         16'h000D: oct = fs_head_reg[7:0];
         `CRC_HI:  oct = crc_reg[15:8]; // [RULE_16]
         `CRC_LO:  oct = crc_reg[7:0];
         default:  oct = ent_ok ? ent_shft[95:88] : 8'h00; // [RULE_15]
      endcase
   end

   // ==============================================
   // location and continuation estimate
   wire [31:0] trk_left = head_reg * spt_reg;
   wire [31:0] cyl_left = trk_left + {16'h0, spt_reg - sector_reg};
   wire [7:0]  sets_rem = sets_run - set_no_reg;
   wire [31:0] need     = {22'h0, sets_rem, 2'h0} - {24'h0, sets_rem} + 32'h3;
   wire        load     = busy && (!rec_valid || rec_ready);
   wire        fld_end  = (idx_reg == `CRC_LO);

   // ==============================================
   // framer
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         state_reg    <= S_IDLE;
         idx_reg      <= 16'h0;
         k_reg        <= 4'h0;
         eif_reg      <= 8'h0;
         set_base_reg <= 8'h0;
         set_no_reg   <= 8'h1;
         copy_reg     <= 2'h0;
         bad_reg      <= 1'b0;
         cont_reg     <= 1'b0;
         crc_reg      <= `CRC_SEED;
         cyl_reg      <= 32'h0;
         head_reg     <= 16'h0;
         sector_reg   <= 16'h0;
         rec_data     <= 8'h00;
         rec_valid    <= 1'b0;
         rec_first    <= 1'b0;
         rec_last     <= 1'b0;
         rec_cyl      <= 32'h0;
         rec_head     <= 16'h0;
         rec_sector   <= 16'h0;
         mfr_format   <= 1'b0;
      end else begin
         mfr_format <= busy || (rec_valid && !rec_ready); // [RULE_18]
         if (rec_valid && rec_ready)
            rec_valid <= 1'b0;
         case (state_reg)
            S_IDLE, S_DONE: begin
               if (start) begin
                  state_reg    <= S_RUN;
                  set_no_reg   <= 8'h1; // [RULE_12]
                  set_base_reg <= 8'h0;
                  copy_reg     <= 2'h0;
                  idx_reg      <= 16'h0;
                  k_reg        <= 4'h0;
                  eif_reg      <= 8'h0;
                  crc_reg      <= `CRC_SEED;
                  cyl_reg      <= map_cyl_reg; // [RULE_01]
                  head_reg     <= map_head_reg;
                  sector_reg   <= 16'h0;
               end
            end
            S_RUN: begin
               if (load) begin
                  rec_data   <= oct;
                  rec_valid  <= 1'b1;
                  rec_first  <= (idx_reg == 16'h0);
                  rec_last   <= fld_end;
                  rec_cyl    <= cyl_reg;
                  rec_head   <= head_reg;
                  rec_sector <= sector_reg;
                  if (idx_reg < `CRC_HI)
                     crc_reg <= crc_byte(crc_reg, oct); // [RULE_23]
                  if (idx_reg == 16'h0) begin
                     bad_reg <= sector_bad; // [RULE_03]
                     if (copy_reg == 2'h0)
                        cont_reg <= (need > cyl_left); // [RULE_09]
                  end
                  if (in_ent) begin // [RULE_07]
                     if (k_reg == `ENT_LAST_OCT) begin
                        k_reg   <= 4'h0;
                        eif_reg <= eif_reg + 8'h1;
                     end else
                        k_reg <= k_reg + 4'h1;
                  end
                  idx_reg <= idx_reg + 16'h1;
                  if (fld_end) begin
                     idx_reg <= 16'h0;
                     k_reg   <= 4'h0;
                     eif_reg <= 8'h0;
                     crc_reg <= `CRC_SEED;
                     if (sector_reg == spt_reg - 16'h1) begin
                        sector_reg <= 16'h0;
                        if (head_reg == 16'h0) begin // [RULE_01]
                           head_reg <= map_head_reg;
                           cyl_reg  <= cyl_reg - 32'h1;
                        end else
                           head_reg <= head_reg - 16'h1;
                     end else
                        sector_reg <= sector_reg + 16'h1;
                     if (!bad_reg) begin // [RULE_02]
                        if (copy_reg == `COPIES_LAST) begin
                           copy_reg <= 2'h0;
                           if (set_no_reg == sets_run)
                              state_reg <= S_DONE;
                           else begin
                              set_no_reg   <= set_no_reg + 8'h1;
                              set_base_reg <= set_base_reg + `ENT_PER_FIELD;
                           end
                        end else
                           copy_reg <= copy_reg + 2'h1;
                     end
                  end
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: sim/defect_map_checker_asserts.sv */
/* checker on the framer record stream.
   assumes a bind onto defect_map_framer, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module defect_map_checker (
   input wire logic        sys_clk,    // clock
   input wire logic        rst_b,      // sync reset
   input wire logic [7:0]  rec_data,   // octet
   input wire logic        rec_valid,  // octet valid
   input wire logic        rec_ready,  // octet taken
   input wire logic        rec_first,  // octet 0
   input wire logic        rec_last,   // octet 255
   input wire logic [31:0] rec_cyl,    // cylinder
   input wire logic        mfr_format  // maker format
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ==============================================
   // octet index and running crc
   logic [7:0]  idx_reg;
   logic [15:0] crc_reg;
   wire         take = rec_valid && rec_ready;
   function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
      return c;
   endfunction
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         idx_reg <= 8'h00;
         crc_reg <= 16'hFFFF;
      end else if (take) begin
         idx_reg <= idx_reg + 8'h01;
         if (idx_reg < 8'hFE)
            crc_reg <= step((idx_reg == 8'h00) ? 16'hFFFF : crc_reg, rec_data);
      end
   end
   // ==============================================
   // assertions
   AST_COUNT_HI: assert property (rec_valid && rec_first |-> rec_data == 8'h00
      && idx_reg == 8'h00) else $error("count high octet wrong");
   AST_COUNT_LO: assert property (take && rec_first |=> rec_valid && rec_data == 8'hFE)
      else $error("count low octet wrong");
   AST_FLAG: assert property (rec_valid && idx_reg == 8'h02 |-> rec_data[2:0] == 3'h0
      && rec_data[5:4] == 2'h0) else $error("flag octet wrong");
   AST_FNUM: assert property (rec_valid && idx_reg == 8'h03 |-> rec_data <= 8'h02
      || rec_data == 8'hFF) else $error("field number illegal");
   AST_LAST: assert property (rec_valid |-> rec_last == (idx_reg == 8'hFF))
      else $error("last octet flag misplaced");
   AST_CRC_HI: assert property (rec_valid && idx_reg == 8'hFE |-> rec_data == crc_reg[15:8])
      else $error("crc high octet wrong");
   AST_CRC_LO: assert property (rec_valid && idx_reg == 8'hFF |-> rec_data == crc_reg[7:0])
      else $error("crc low octet wrong");
   AST_HOLD: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
      else $error("octet dropped while stalled");
   AST_FMT: assert property (rec_valid |-> mfr_format)
      else $error("maker format not selected");
   AST_CYL: assert property (take && !rec_last |=> $stable(rec_cyl))
      else $error("cylinder moved inside a field");
   cover property (take && idx_reg == 8'h03 && rec_data == 8'hFF);
   cover property (take && rec_last);
   cover property (rec_valid && !rec_ready);
endmodule
bind defect_map_framer defect_map_checker u_chk (.sys_clk, .rst_b, .rec_data, .rec_valid,
   .rec_ready, .rec_first, .rec_last, .rec_cyl, .mfr_format);
`default_nettype wire

/* File: sim/map_reader_model.sv */
/* formatter and map reader model on the record stream.
   assumes stall comes from the bench, one clock. */
`timescale 1ns/100ps
`default_nettype none
module map_reader_model #(parameter int BAD_FIELD = 1) (
   input wire logic       sys_clk,     // clock
   input wire logic       rst_b,       // sync reset
   input wire logic [7:0] rec_data,    // octet
   input wire logic       rec_valid,   // octet valid
   input wire logic       rec_last,    // octet 255
   input wire logic       stall,       // hold off octets
   output wire logic      rec_ready,   // octet taken
   output wire logic      sector_bad,  // sector unreadable
   output logic [7:0]     good_fields  // fields kept
);
   logic [7:0] done_reg;
   logic [7:0] idx_reg;
   assign rec_ready = rst_b && !stall;
   assign sector_bad = ((done_reg + {7'h00, rec_valid && rec_ready && rec_last})
      == BAD_FIELD[7:0]);
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         done_reg <= 8'h00;
         idx_reg <= 8'h00;
         good_fields <= 8'h00;
      end else if (rec_valid && rec_ready) begin
         idx_reg <= rec_last ? 8'h00 : idx_reg + 8'h01;
         if (rec_last)
            done_reg <= done_reg + 8'h01;
         if (idx_reg == 8'h03 && rec_data <= 8'h02)
            good_fields <= good_fields + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
/* self-checking bench for the defect map framer.
   assumes the checker bind and the reader model. */
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, rec_data, good_fields, f[256];
   logic [31:0] s_axi_wdata, s_axi_rdata, rec_cyl, rv, d1, d2;
   logic [31:0] rnd = 32'hD79F780E;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic        sys_clk, rst_b, rec_valid, rec_ready, rec_first, rec_last, sector_bad;
   logic        mfr_format, stall;
   logic [15:0] rec_head, rec_sector;
   logic [191:0] ent;
   logic [73:0] exp_q[$];
   int          n_errors, checks_done;
   defect_map_framer u_dut (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .rec_data, .rec_valid, .rec_ready, .rec_first, .rec_last,
      .rec_cyl, .rec_head, .rec_sector, .sector_bad, .mfr_format);
   map_reader_model u_rdr (.sys_clk, .rst_b, .rec_data, .rec_valid, .rec_last, .stall,
      .rec_ready, .sector_bad, .good_fields);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // ==============================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         c = (c << 1) ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
      return c;
   endfunction
   task automatic check(input string nm, input logic [79:0] seen, input logic [79:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ==============================================
   // axi4-lite master
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      check("bresp", s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      check("rresp", s_axi_rresp, (a < 8'h2C) ? 2'h0 : 2'h2);
      s_axi_rready <= 1'b0;
   endtask
   // ==============================================
   // expected fields and completion
   task automatic push_set(input logic [31:0] nums, input int ncopy);
      logic [15:0] c;
      for (int k = 0; k < ncopy; k++) begin
         f[3] = nums[31-8*k -: 8];
         c = 16'hFFFF;
         for (int i = 0; i < 254; i++) c = crc8(c, f[i]);
         {f[254], f[255]} = c;
         for (int i = 0; i < 256; i++)
            exp_q.push_back({i == 0, i == 255, f[i], 16'h1, 16'(k), 32'h5});
      end
   endtask
   task automatic end_run(input logic [17:0] st);
      while (exp_q.size() != 0) @(posedge sys_clk);
      for (int n = 0; n < 50 && !(rv[30] && !rv[31]); n++) rd(8'h04);
      check("status", {rv[31:29], rv[15:8], rv[6:0]}, st);
   endtask
   always @(posedge sys_clk) begin
      rnd <= lfsr(rnd);
      stall <= rnd[1] & rnd[4];
      if (rst_b && rec_valid && rec_ready)
         if (exp_q.size() == 0) check("extra octet", 1, 0);
         else check("octet", {rec_first, rec_last, rec_data, rec_head, rec_sector, rec_cyl},
            exp_q.pop_front());
   end
   initial begin
      repeat (30000) @(posedge sys_clk);
      n_errors++;
      tally_and_finish();
   end
   // ==============================================
   // main sequence
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_arvalid, s_axi_rready, stall, rst_b} = '0;
      s_axi_wstrb = 4'hF;
      rv = '0;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      d1 = {16'h0, rnd[15:0]};
      d2 = {16'h0, rnd[31:16]};
      wr(8'h08, 32'h5);
      wr(8'h0C, 32'h0004_0001);
      wr(8'h10, 32'h4);
      wr(8'h14, 32'h1);
      wr(8'h18, 32'h3E8);
      wr(8'h1C, 32'h10);
      wr(8'h20, 32'h0002_0002);
      wr(8'h24, d1);
      wr(8'h28, 32'h7);
      wr(8'h1C, 32'h3);
      wr(8'h20, 32'h0);
      wr(8'h24, d2);
      wr(8'h28, 32'h9);
      wr(8'h44, 32'h1, 2'h2);
      rd(8'h40);
      check("unmapped read", rv, 0);
      rd(8'h08);
      check("map cylinder", rv, 32'h5);
      foreach (f[i]) f[i] = 8'h00;
      {f[1], f[2], f[5], f[7], f[11], f[13]} = {8'hFE, 8'h88, 8'h01, 8'h01, 8'h04, 8'h01};
      ent = {32'h10, 16'h2, d1 + 32'd2000, 16'h7, 32'h3, 16'h0, d2, 16'h9};
      for (int j = 0; j < 24; j++) f[14+j] = ent[191-8*j -: 8];
      push_set(32'h00FF_0102, 4);
      wr(8'h00, 32'h1);
      end_run({3'b010, 8'h01, 7'h02});
      check("good fields", good_fields, 8'h03);
      wr(8'h00, 32'h2);
      for (int j = 14; j < 38; j++) f[j] = 8'h00;
      {f[2], f[5]} = {8'h80, 8'h00};
      push_set(32'h0001_0200, 3);
      wr(8'h00, 32'h1);
      rv = '0;
      end_run({3'b010, 8'h00, 7'h00});
      tally_and_finish();
   end
endmodule
`default_nettype wire
